/* logic/amc_pkg.sv */
// Package for the averaging and mode control block of an eight-channel sampling converter.
// Assumes a single 40 MHz clock; all cycle counts are derived from that rate.
package amc_pkg;

   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned CLK_PERIOD_PS   = 25_000;
   // Reset pulse classes and setup times, in nanoseconds as printed.
   localparam int unsigned RST_MIN_NS      = 50;
   localparam int unsigned RST_PART_MAX_NS = 2_000;
   localparam int unsigned RST_FULL_NS     = 3_000;
   localparam int unsigned SETUP_FULL_NS   = 253_000;
   localparam int unsigned SETUP_PART_NS   = 50;
   // Least times round up to whole cycles; the full setup time divides without rounding.
   localparam int unsigned RST_MIN_CYC     = (RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned RST_PART_CYC    = (RST_PART_MAX_NS * 1000) / CLK_PERIOD_PS;
   localparam int unsigned RST_FULL_CYC    = (RST_FULL_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned SETUP_PART_CYC  = (SETUP_PART_NS * 1000 + CLK_PERIOD_PS - 1)
                                             / CLK_PERIOD_PS;
   localparam int unsigned SETUP_FULL_CYC  = SETUP_FULL_NS * 1000 / CLK_PERIOD_PS;
   // Fastest sample rate: 800 kSPS gives the least spacing between conversion starts.
   localparam int unsigned MAX_SPS         = 800_000;
   localparam int unsigned CONV_MIN_CYC    = CLK_HZ / MAX_SPS;

   localparam int unsigned NUM_CH          = 8;
   localparam int unsigned SAMPLE_W        = 16;
   localparam int unsigned ACC_W           = SAMPLE_W + 8;
   localparam logic [2:0]  OS_SW_CODE      = 3'h7;
   localparam logic [3:0]  OS_MAX_SW       = 4'h8;
   localparam logic [2:0]  OS_RESET        = 3'h0;
   // Synchroniser value at reset matches the idle pins, so no false edge follows reset.
   localparam logic [7:0]  PIN_IDLE        = 8'h40;

   typedef enum logic [1:0] {AMC_LANES_1, AMC_LANES_2, AMC_LANES_4} amc_lanes_t;

   // Software-mode configuration, written through the register port.
   typedef struct packed {
      logic [3:0]             os_log2;
      amc_lanes_t             lanes;
      logic [NUM_CH-1:0]      range_lo;
      logic [NUM_CH-1:0]      range_2v5;
      logic                   comp_en;
      logic                   disc_en;
      logic                   diag_en;
   } amc_swcfg_t;

   typedef struct packed {
      logic                   valid;
      logic [SAMPLE_W-1:0]    data;
   } amc_sample_t;

endpackage

/* logic/amc_avg.sv */
// One channel averaging engine: sums 2**os_log2 samples and delivers the mean.
// Assumes samples arrive from the converter core on the same clock.
`timescale 1ns/1ps
module amc_avg
   import amc_pkg::*;
#(
   parameter int unsigned W = SAMPLE_W
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          clr,
   // Setting
   input  wire logic [3:0]    os_log2,
   // Sample stream
   input  wire logic          in_valid,
   input  wire logic [W-1:0]  in_data,
   output logic               out_valid,
   output logic [W-1:0]       out_data
);

   logic [W+7:0] acc_q;
   logic [8:0]   cnt_q;
   wire  [8:0]   target   = 9'(1) << os_log2;
   wire  [W+7:0] sum      = acc_q + (W+8)'(in_data);
   wire          last     = in_valid && (9'(cnt_q + 9'h1) == target);
   wire  [W+7:0] mean     = sum >> os_log2;

   // The mean covers consecutive conversions of this channel only.
   always_ff @(posedge clk) begin
      if (clr) begin
         acc_q     <= '0;
         cnt_q     <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         out_valid <= last;
         if (last) begin
            out_data <= mean[W-1:0];
            acc_q    <= '0;
            cnt_q    <= '0;
         end else if (in_valid) begin
            acc_q <= sum;
            cnt_q <= 9'(cnt_q + 9'h1);
         end
      end
   end

endmodule // amc_avg

/* logic/amc_ctrl.sv */
// Mode, averaging and reset control for an eight-channel simultaneous-sampling converter.
// Assumes the control pins come from a host outside this clock domain.
`timescale 1ns/1ps
// What this block does
// - Pin code 000 means no averaging; 001 to 110 pick factors 2 to 64.
// - Pin code 111 enters software mode instead of picking a factor.
// - In software mode the averaging factor comes from a register, not pins.
// - Averaging pins are caught when reset falls and held until the next reset.
// - Software mode also allows averaging factors 128 and 256.
// - Interface select low picks parallel, high picks serial; no byte mode.
// - Software mode serial output uses one, two or four data lines.
// - Serial register commands enter on the shared parallel data bit line.
// - Parallel register access needs its own write strobe, apart from start.
// - Software mode picks range per channel, including 2.5 V; else common.
// - Conversion starts are accepted at rates up to 800 kSPS.
// - Compensation, disconnect detection and diagnostics exist only in software mode.
// - One conversion start samples all eight channels together.
// - Reset 50 ns to under 2 us is partial; 3 us or more is full.
// - With four serial lines, two parallel data bits become outputs three and four.
module amc_ctrl
   import amc_pkg::*;
#(
   parameter int unsigned SETUP_CYC = SETUP_FULL_CYC
) (
   // Clock and reset
   input  wire logic                 clk,
   input  wire logic                 rst_n,
   // Host control pins
   input  wire logic                 reset_pin,
   input  wire logic                 averaging_sel_bit0,
   input  wire logic                 averaging_sel_bit1,
   input  wire logic                 averaging_sel_bit2,
   input  wire logic                 interface_select,
   input  wire logic                 conversion_start_pin,
   input  wire logic                 reg_write_n,
   input  wire logic                 shared_serial_cmd_input,
   // Software configuration from the register decoder
   input  wire logic                 cfg_wr,
   input  wire amc_swcfg_t           cfg_in,
   // Converter core samples, all channels together
   input  wire logic                 core_valid,
   input  wire logic [NUM_CH*SAMPLE_W-1:0] core_data,
   // Status and steering
   output logic                      sw_mode,
   output logic                      serial_mode,
   output logic [3:0]                averaging_factor,
   output logic                      sample_all,
   output logic                      ready,
   output logic                      reg_strobe,
   output logic                      reg_sdi,
   output logic [1:0]                serial_lanes,
   output logic                      third_serial_output_en,
   output logic                      fourth_serial_output_en,
   output logic [NUM_CH-1:0]         range_lo,
   output logic [NUM_CH-1:0]         range_2v5,
   output logic                      comp_en,
   output logic                      disc_en,
   output logic                      diag_en,
   output logic                      partial_reset,
   output logic                      full_reset,
   output logic [NUM_CH-1:0]         result_valid,
   output logic [NUM_CH*SAMPLE_W-1:0] result_data
);

   // Two-flop synchronisers for every pin; only the second stage is read.
   logic [7:0] pin_m_q, pin_s_q;
   wire  [7:0] pins = {shared_serial_cmd_input, reg_write_n, conversion_start_pin,
                       interface_select, averaging_sel_bit2, averaging_sel_bit1,
                       averaging_sel_bit0, reset_pin};
   wire        rst_s   = pin_s_q[0];
   wire  [2:0] os_pins = pin_s_q[3:1];
   wire        sel_s   = pin_s_q[4];
   wire        cs_s    = pin_s_q[5];
   wire        wr_n_s  = pin_s_q[6];
   wire        sdi_s   = pin_s_q[7];

   logic        rst_prev_q, cs_prev_q, wr_prev_q;
   logic [19:0] rst_len_q, wait_q, gap_q;
   logic [2:0]  os_pins_q;
   logic        sel_q, sw_q;
   amc_swcfg_t  cfg_q;

   wire rst_fall   = rst_prev_q && !rst_s;
   wire rst_rise   = !rst_prev_q && rst_s;
   wire len_part   = rst_len_q >= 20'(RST_MIN_CYC) && rst_len_q < 20'(RST_PART_CYC);
   wire len_full   = rst_len_q >= 20'(RST_FULL_CYC);
   wire cs_rise    = cs_s && !cs_prev_q;
   // Tying the write strobe to the start pin makes both edges coincide, so no access.
   wire wr_rise    = wr_n_s && !wr_prev_q && !cs_rise;
   wire rst_hit    = rst_fall && (len_part || len_full);
   // A start in the cycle that reloads the setup wait would slip past that wait.
   wire start_ok   = cs_rise && wait_q == '0 && gap_q == '0 && !rst_hit;

   function automatic logic [3:0] eff_os(input logic sw, input logic [2:0] p,
                                         input logic [3:0] r);
      // Software register may reach 8 (256); pins give the code itself as log2.
      eff_os = sw ? ((r > OS_MAX_SW) ? OS_MAX_SW : r) : {1'b0, p};
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pin_m_q <= PIN_IDLE;
         pin_s_q <= PIN_IDLE;
      end else begin
         pin_m_q <= pins;
         pin_s_q <= pin_m_q;
      end
   end

   // Reset pulse width measurement and classification.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rst_prev_q    <= 1'b0;
         rst_len_q     <= '0;
         partial_reset <= 1'b0;
         full_reset    <= 1'b0;
      end else begin
         rst_prev_q    <= rst_s;
         // The rising cycle counts too, so a pulse of n cycles reads as n.
         if (rst_rise)
            rst_len_q <= 20'h1;
         else if (rst_s && rst_len_q != '1)
            rst_len_q <= rst_len_q + 20'h1;
         partial_reset <= rst_fall && len_part;
         full_reset    <= rst_fall && len_full;
      end
   end

   // Pins are latched at the falling edge of the reset pin; gaps between 2 and 3 us
   // are treated as a full reset would not be, so they leave the setting untouched.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         os_pins_q <= OS_RESET;
         sel_q     <= 1'b0;
         sw_q      <= 1'b0;
         cfg_q     <= '0;
      end else begin
         if (rst_hit) begin
            os_pins_q <= os_pins;
            sel_q     <= sel_s;
            sw_q      <= os_pins == OS_SW_CODE;
         end
         if (rst_fall && len_full)
            cfg_q <= '0;
         else if (cfg_wr && sw_q && (sel_q ? sdi_s : wr_rise))
            cfg_q <= cfg_in;
      end
   end

   // Setup delay after reset, and spacing of starts for 800 kSPS.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wait_q    <= 20'(SETUP_CYC);
         gap_q     <= '0;
         cs_prev_q <= 1'b0;
         wr_prev_q <= 1'b1;
      end else begin
         cs_prev_q <= cs_s;
         wr_prev_q <= wr_n_s;
         if (rst_fall && len_full)
            wait_q <= 20'(SETUP_CYC);
         else if (rst_fall && len_part)
            wait_q <= 20'(SETUP_PART_CYC);
         else if (wait_q != '0)
            wait_q <= wait_q - 20'h1;
         if (start_ok)
            gap_q <= 20'(CONV_MIN_CYC - 1);
         else if (gap_q != '0)
            gap_q <= gap_q - 20'h1;
      end
   end

   // Hardware mode forces common range and no extras.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw_mode                 <= 1'b0;
         serial_mode             <= 1'b0;
         averaging_factor        <= '0;
         sample_all              <= 1'b0;
         ready                   <= 1'b0;
         reg_strobe              <= 1'b0;
         reg_sdi                 <= 1'b0;
         serial_lanes            <= 2'h0;
         third_serial_output_en  <= 1'b0;
         fourth_serial_output_en <= 1'b0;
         range_lo                <= '0;
         range_2v5               <= '0;
         comp_en                 <= 1'b0;
         disc_en                 <= 1'b0;
         diag_en                 <= 1'b0;
      end else begin
         sw_mode          <= sw_q;
         serial_mode      <= sel_q;
         averaging_factor <= eff_os(sw_q, os_pins_q, cfg_q.os_log2);
         sample_all       <= start_ok && !rst_s;
         ready            <= wait_q == '0 && !rst_s && !rst_hit;
         reg_strobe       <= sw_q && !sel_q && wr_rise;
         reg_sdi          <= sw_q && sel_q && sdi_s;
         serial_lanes     <= sw_q ? cfg_q.lanes : AMC_LANES_2;
         third_serial_output_en  <= sw_q && sel_q && cfg_q.lanes == AMC_LANES_4;
         fourth_serial_output_en <= sw_q && sel_q && cfg_q.lanes == AMC_LANES_4;
         range_lo         <= sw_q ? cfg_q.range_lo  : {NUM_CH{cfg_q.range_lo[0]}};
         range_2v5        <= sw_q ? cfg_q.range_2v5 : '0;
         comp_en          <= sw_q && cfg_q.comp_en;
         disc_en          <= sw_q && cfg_q.disc_en;
         diag_en          <= sw_q && cfg_q.diag_en;
      end
   end

   wire clr_avg = !rst_n || partial_reset || full_reset;

   genvar ch;
   generate
      for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
         amc_avg #(.W(SAMPLE_W)) u_avg (
            .clk       (clk),
            .clr       (clr_avg),
            .os_log2   (averaging_factor),
            .in_valid  (core_valid),
            .in_data   (core_data[ch*SAMPLE_W +: SAMPLE_W]),
            .out_valid (result_valid[ch]),
            .out_data  (result_data[ch*SAMPLE_W +: SAMPLE_W])
         );
      end
   endgenerate

   // Latched at the reset fall, then one more cycle to reach the output flop.
   sequence s_full_111;
      rst_fall && len_full && os_pins == OS_SW_CODE;
   endsequence
   property p_sw_on_111;
      @(posedge clk) disable iff (!rst_n)
      s_full_111 |=> ##1 sw_mode;
   endproperty
   a_sw_on_111: assert property (p_sw_on_111) else $error("code 111 missed");

   property p_pins_factor;
      @(posedge clk) disable iff (!rst_n)
      !sw_q && $stable(os_pins_q) |=> averaging_factor == {1'b0, $past(os_pins_q)};
   endproperty
   a_pins_factor: assert property (p_pins_factor) else $error("bad pin factor");

   property p_sw_max;
      @(posedge clk) disable iff (!rst_n) sw_mode |-> averaging_factor <= OS_MAX_SW;
   endproperty
   a_sw_max: assert property (p_sw_max) else $error("factor above 256");

   property p_hold;
      @(posedge clk) disable iff (!rst_n) !rst_fall |=> $stable(os_pins_q);
   endproperty
   a_hold: assert property (p_hold) else $error("pins relatched");

   property p_no_early;
      @(posedge clk) disable iff (!rst_n) wait_q != '0 |=> !sample_all;
   endproperty
   a_no_early: assert property (p_no_early) else $error("start in setup");

   property p_hw_extras;
      @(posedge clk) disable iff (!rst_n)
      !sw_mode |-> !comp_en && !disc_en && !diag_en && range_2v5 == '0;
   endproperty
   a_hw_extras: assert property (p_hw_extras) else $error("extras in hw mode");

   property p_lanes4;
      @(posedge clk) disable iff (!rst_n)
      fourth_serial_output_en |-> sw_mode && serial_mode;
   endproperty
   a_lanes4: assert property (p_lanes4) else $error("lane 4 misused");

   property p_part_class;
      @(posedge clk) disable iff (!rst_n)
      partial_reset |-> !full_reset;
   endproperty
   a_part_class: assert property (p_part_class) else $error("reset class clash");

endmodule // amc_ctrl

/* bench/amc_host.sv */
// Host model that drives the control pins of the averaging and mode control block.
// Assumes the bench calls its tasks one at a time; pins move 1 ns after a rising edge.
`timescale 1ns/1ps
module amc_host
   import amc_pkg::*;
(
   // Clock and status
   input  wire logic  clk,
   input  wire logic  ready,
   // Control pins
   output logic       reset_pin,
   output logic [2:0] os_code,
   output logic       interface_select,
   output logic       conversion_start_pin,
   output logic       reg_write_n,
   output logic       shared_serial_cmd_input
);
   initial begin
      reset_pin = 1'b0;
      os_code = 3'h0;
      interface_select = 1'b0;
      conversion_start_pin = 1'b0;
      reg_write_n = 1'b1;
      shared_serial_cmd_input = 1'b0;
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // The command line is driven, never left floating; it stays grounded when unused.
   task automatic set_pins(input logic [2:0] code, input logic sel, input logic sdi);
      os_code = code;
      interface_select = sel;
      shared_serial_cmd_input = sdi;
   endtask
   task automatic pulse_reset(input int n);
      reset_pin = 1'b1;
      step(n);
      reset_pin = 1'b0;
   endtask
   // A strobe of its own; tying it to the start pin would lock the registers out.
   task automatic write_strobe();
      reg_write_n = 1'b0;
      step(2);
      reg_write_n = 1'b1;
   endtask
   // Strobe tied to the start pin: both rise in one step, so no register access.
   task automatic tied_start();
      reg_write_n = 1'b0;
      step(3);
      reg_write_n = 1'b1;
      conversion_start_pin = 1'b1;
      step(2);
      conversion_start_pin = 1'b0;
   endtask
   task automatic start_pulse();
      conversion_start_pin = 1'b1;
      step(2);
      conversion_start_pin = 1'b0;
   endtask
   // Waits out the setup time, bounded so that a stuck device cannot hang the run.
   task automatic wait_ready(output logic ok);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 500) begin
         step(1);
         n++;
      end
      ok = (ready === 1'b1);
   endtask
endmodule // amc_host

/* bench/amc_ctrl_test.sv */
// Self-checking bench for the averaging and mode control block.
// Assumes amc_host drives the pins; the bench drives reset, configuration and core samples.
`timescale 1ns/1ps
module amc_ctrl_test
   import amc_pkg::*;
;
   localparam int unsigned SETUP = 20;
   localparam int unsigned DW    = NUM_CH * SAMPLE_W;
   logic              clk;
   logic              rst_n;
   logic              cfg_wr;
   amc_swcfg_t        cfg_in;
   logic              core_valid;
   logic [DW-1:0]     core_data;
   logic              reset_pin, interface_select, conversion_start_pin;
   logic              reg_write_n, shared_serial_cmd_input;
   logic [2:0]        os_code;
   logic              sw_mode, serial_mode, sample_all, ready, third_en, fourth_en;
   logic              comp_en, disc_en, diag_en, partial_reset, full_reset;
   logic [3:0]        averaging_factor;
   logic              reg_strobe, reg_sdi;
   logic [1:0]        serial_lanes;
   logic [NUM_CH-1:0] range_lo, range_2v5, result_valid;
   logic [DW-1:0]     result_data;
   logic [DW-1:0]     exp_q[$];
   int                num_errors = 0;
   int                comparisons = 0;
   int                n_samp, n_part, n_full, n_strb;
   int                cyc = 0;
   integer            seed = 32'h422ee941;
   int                widths[8] = '{1, 40, 100, 130, 2, 79, 80, 120};
   logic [15:0]       exp_rst[8] = '{16'h0, 16'h2, 16'h0, 16'h1, 16'h2, 16'h2, 16'h0, 16'h1};

   amc_host u_host (.clk(clk), .ready(ready), .reset_pin(reset_pin), .os_code(os_code),
      .interface_select(interface_select), .conversion_start_pin(conversion_start_pin),
      .reg_write_n(reg_write_n), .shared_serial_cmd_input(shared_serial_cmd_input));

   amc_ctrl #(.SETUP_CYC(SETUP)) u_dut (.clk(clk), .rst_n(rst_n), .reset_pin(reset_pin),
      .averaging_sel_bit0(os_code[0]), .averaging_sel_bit1(os_code[1]),
      .averaging_sel_bit2(os_code[2]), .interface_select(interface_select),
      .conversion_start_pin(conversion_start_pin), .reg_write_n(reg_write_n),
      .shared_serial_cmd_input(shared_serial_cmd_input), .cfg_wr(cfg_wr), .cfg_in(cfg_in),
      .core_valid(core_valid), .core_data(core_data), .sw_mode(sw_mode),
      .serial_mode(serial_mode), .averaging_factor(averaging_factor),
      .sample_all(sample_all), .ready(ready), .reg_strobe(reg_strobe), .reg_sdi(reg_sdi),
      .serial_lanes(serial_lanes),
      .third_serial_output_en(third_en), .fourth_serial_output_en(fourth_en),
      .range_lo(range_lo), .range_2v5(range_2v5), .comp_en(comp_en), .disc_en(disc_en),
      .diag_en(diag_en), .partial_reset(partial_reset), .full_reset(full_reset),
      .result_valid(result_valid), .result_data(result_data));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic cmp_data(input logic [DW-1:0] e, input logic [DW-1:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic cmp_bits(input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("Error at %0t: expected %h got %h", $time, e, g);
      end
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   function automatic logic [15:0] mode_word();
      return {7'h0, comp_en, disc_en, diag_en, sw_mode, serial_mode, averaging_factor};
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Results are checked as they appear, against the oldest note of the driver.
   always @(posedge clk) begin
      if (sample_all === 1'b1) n_samp++;
      if (partial_reset === 1'b1) n_part++;
      if (full_reset === 1'b1) n_full++;
      if (reg_strobe === 1'b1) n_strb++;
      if (rst_n === 1'b1 && result_valid !== 8'h00) begin
         cmp_bits(16'h00ff, 16'(result_valid));
         if (exp_q.size() == 0) cmp_bits(16'h0, 16'(result_valid));
         else cmp_data(exp_q.pop_front(), result_data);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         num_errors++;
         give_verdict();
      end
   end

   // Sample MSBs are cleared so the mean does not depend on signedness.
   task automatic feed(input int lg);
      logic [DW-1:0] d;
      logic [DW-1:0] e;
      logic [31:0]   s [NUM_CH];
      for (int c = 0; c < NUM_CH; c++) s[c] = 32'h0;
      for (int i = 0; i < (1 << lg); i++) begin
         for (int c = 0; c < NUM_CH; c++) begin
            d[c*SAMPLE_W +: SAMPLE_W] = 16'($random(seed)) & 16'h7fff;
            s[c] = s[c] + 32'(d[c*SAMPLE_W +: SAMPLE_W]);
            e[c*SAMPLE_W +: SAMPLE_W] = 16'(s[c] >> lg);
         end
         if (i == (1 << lg) - 1) exp_q.push_back(e);
         core_data = d;
         core_valid = 1'b1;
         step(1);
         core_valid = 1'b0;
         step(1);
      end
      repeat (20) if (exp_q.size() != 0) step(1);
      cmp_bits(16'h0, 16'(exp_q.size()));
   endtask
   task automatic write_cfg(input amc_swcfg_t v, input int hold);
      cfg_in = v;
      cfg_wr = 1'b1;
      step(hold);
      cfg_wr = 1'b0;
      step(4);
   endtask
   task automatic hw_reset(input logic [2:0] code, input logic sel, input logic sdi);
      logic ok;
      u_host.set_pins(code, sel, sdi);
      u_host.pulse_reset(130);
      step(6);
      u_host.wait_ready(ok);
      cmp_bits(16'h1, 16'(ok));
   endtask

   initial begin
      logic       ok;
      amc_swcfg_t c;
      rst_n = 1'b0;
      cfg_wr = 1'b0;
      cfg_in = '0;
      core_valid = 1'b0;
      core_data = '0;
      step(3);
      rst_n = 1'b1;
      step(1);
      n_samp = 0;
      u_host.start_pulse();
      step(8);
      cmp_bits(16'h0, 16'(n_samp));
      u_host.wait_ready(ok);
      cmp_bits(16'h1, 16'(ok));
      // The middle start falls inside the minimum spacing and must be dropped.
      for (int i = 0; i < 3; i++) begin
         n_samp = 0;
         u_host.start_pulse();
         step(i == 1 ? 50 : 8);
         cmp_bits(i == 1 ? 16'h0 : 16'h1, 16'(n_samp));
      end
      for (int i = 0; i < 8; i++) begin
         n_part = 0;
         n_full = 0;
         u_host.pulse_reset(widths[i]);
         step(10);
         u_host.wait_ready(ok);
         cmp_bits(exp_rst[i], 16'(n_part * 2 + n_full));
      end
      c = '0;
      c.range_lo = 8'($random(seed));
      c.range_2v5 = 8'($random(seed));
      c.comp_en = 1'b1;
      c.diag_en = 1'b1;
      c.lanes = AMC_LANES_4;
      c.os_log2 = 4'h8;
      for (int k = 0; k < 7; k++) begin
         hw_reset(3'(k), 1'(k), 1'b0);
         u_host.set_pins(3'(~k), 1'(~k), 1'b0);
         write_cfg(c, 1);
         cmp_bits({11'h0, 1'(k), 4'(k)}, mode_word());
         cmp_bits(16'(AMC_LANES_2), {14'h0, serial_lanes});
         if (k < 3) feed(k);
      end
      hw_reset(3'h7, 1'b1, 1'b0);
      cmp_bits(16'h0030, mode_word());
      write_cfg(c, 1);
      cmp_bits(16'h0030, mode_word());
      u_host.set_pins(3'h0, 1'b1, 1'b1);
      step(3);
      write_cfg(c, 1);
      cmp_bits(16'h0178, mode_word());
      cmp_bits({c.range_lo, c.range_2v5}, {range_lo, range_2v5});
      cmp_bits(16'h3, {14'h0, third_en, fourth_en});
      cmp_bits(16'(AMC_LANES_4), {14'h0, serial_lanes});
      cmp_bits(16'h1, {15'h0, reg_sdi});
      feed(8);
      hw_reset(3'h7, 1'b0, 1'b0);
      c.os_log2 = 4'h7;
      c.lanes = AMC_LANES_1;
      n_strb = 0;
      fork
         write_cfg(c, 10);
         begin
            step(1);
            u_host.write_strobe();
         end
      join
      cmp_bits(16'h0167, mode_word());
      cmp_bits(16'h0, {14'h0, third_en, fourth_en});
      cmp_bits(16'h1, 16'(n_strb));
      cmp_bits(16'(AMC_LANES_1), {14'h0, serial_lanes});
      // A strobe that rises with the start pin must leave the setting alone.
      c.os_log2 = 4'h1;
      n_strb = 0;
      fork
         write_cfg(c, 10);
         begin
            step(1);
            u_host.tied_start();
         end
      join
      cmp_bits(16'h0167, mode_word());
      cmp_bits(16'h0, 16'(n_strb));
      give_verdict();
   end
endmodule // amc_ctrl_test
